// *** fcds_pkg.sv ***
// constants and types of the four-channel transfer sequencer
// ==================================================================
// Notes on behaviour
// - each of four channels moves a byte block alone, up to 16,365 bytes
// - any request leaves idle for the request state, raises hold, waits grant
// - in the request state requests are sampled and a winner is resolved
// - after grant the winning channel's grant line is driven low
// - low address byte goes straight out on the address pins
// - high address byte goes on the data pins for an outside latch
// - bus is kept while the request stays high or until count done
// - count done goes high when a channel's count is exhausted
// - three modes: read, write and verify
// - verify sequences as usual, grants and addresses, but no strobes
// - seven states, request, idle, four transfer, wait; transfer states one clock each
// - each cycle runs the first to fourth transfer states in order
// - no ready by the third state inserts wait states until ready
// - extended write or verify may remove any wait state
// - losing the grant finishes the cycle, then idles until granted again
// - write cycles: io read at second state, memory write at third
// - read cycles: memory read at second state, io write at third
// - hold request is set while any request is active
// - hold request clears when no request is active and no cycle is under way
// - block mark pulses once every 128 transfer cycles on a channel
package fcds_pkg;
  // ================================================================
  // register map
  localparam logic [7:0] ADDR_CH_BASE = 8'h00;
  localparam logic [7:0] ADDR_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] CH_STRIDE_SH = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h40;
  localparam logic [7:0] ADDR_STATUS  = 8'h44;
  // ================================================================
  // fields
  localparam int MODE_LSB     = 0;
  localparam int CTRL_EN_LSB  = 0;
  localparam int CTRL_EXTW    = 4;
  localparam int CTRL_ROT     = 5;
  localparam int STAT_DONE    = 0;
  localparam int COUNT_W      = 14;
  localparam logic [13:0] MAX_COUNT = 14'd16364;
  localparam logic [6:0]  MARK_MOD  = 7'h7f;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  // ================================================================
  // types
  typedef enum logic [1:0] {
    XF_VERIFY = 2'b00,
    XF_WRITE  = 2'b01,
    XF_READ   = 2'b10
  } fcds_mode_t;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_REQ    = 7'b0000010,
    ST_FIRST  = 7'b0000100,
    ST_SECOND = 7'b0001000,
    ST_THIRD  = 7'b0010000,
    ST_WAIT   = 7'b0100000,
    ST_FOURTH = 7'b1000000
  } fcds_state_t;
endpackage

// *** fcds_sequencer.sv ***
// four-channel transfer sequencer with apb channel programming
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module fcds_sequencer #(
  parameter int CHANNELS = 4
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  channel_request,
  input  wire logic        bus_hold_grant,
  input  wire logic        ready,
  output logic             bus_hold_request,
  output logic [3:0]       channel_grant_n,
  output logic [7:0]       addr_lo,
  output logic [7:0]       data_out,
  output logic             data_oe_n,
  output logic             addr_strobe,
  output logic             mem_read_strobe_n,
  output logic             mem_write_strobe_n,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             count_done,
  output logic             block_mark
);
  initial begin
    if (CHANNELS != 4) $error("fcds_sequencer serves exactly four channels");
  end
  // ================================================================
  // state
  typedef enum logic [6:0] {
    S_IDLE   = 7'b0000001,
    S_REQ    = 7'b0000010,
    S_FIRST  = 7'b0000100,
    S_SECOND = 7'b0001000,
    S_THIRD  = 7'b0010000,
    S_WAIT   = 7'b0100000,
    S_FOURTH = 7'b1000000
  } fcds_st_t;
  fcds_st_t    state;
  fcds_st_t    next_state;
  logic [15:0] ch_addr  [4];
  logic [13:0] ch_count [4];
  logic [1:0]  ch_mode  [4];
  logic [3:0]  ch_en;
  logic        ext_write;
  logic [3:0]  done_flags;
  logic [1:0]  cur;
  logic [6:0]  mark_cnt [4];
  logic [3:0]  active_req;
  logic        any_req;
  // ================================================================
  // functions
  function automatic logic [1:0] fcds_pick(input logic [3:0] r);
    // fixed rank, channel zero first
    if (r[0]) return 2'd0;
    else if (r[1]) return 2'd1;
    else if (r[2]) return 2'd2;
    else return 2'd3;
  endfunction
  function automatic logic [1:0] fcds_ch(input logic [7:0] a);
    return a[5:4];
  endfunction
  assign active_req = channel_request & ch_en;
  assign any_req    = |active_req;
  // ================================================================
  // apb slave, zero wait
  logic wr_acc;
  logic rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[7:6] != 2'b00) &&
                 (paddr != fcds_pkg::ADDR_CTRL) && (paddr != fcds_pkg::ADDR_STATUS);
      if (rd_acc) begin
        if (paddr == fcds_pkg::ADDR_CTRL)
          prdata <= {26'h0, ext_write, 1'b0, ch_en};
        else if (paddr == fcds_pkg::ADDR_STATUS)
          prdata <= {24'h0, 1'b0, bus_hold_request, cur, done_flags};
        else if (paddr[7:6] == 2'b00) begin
          case (paddr[3:2])
            2'd0:    prdata <= {16'h0, ch_addr[fcds_ch(paddr)]};
            2'd1:    prdata <= {18'h0, ch_count[fcds_ch(paddr)]};
            2'd2:    prdata <= {30'h0, ch_mode[fcds_ch(paddr)]};
            default: prdata <= 32'h0000_0000;
          endcase
        end else
          prdata <= 32'h0000_0000;
      end
    end
  end
  // ================================================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:   next_state = any_req ? S_REQ : S_IDLE;
      // wait in request state for grant
      S_REQ:    next_state = !any_req ? S_IDLE : (bus_hold_grant ? S_FIRST : S_REQ);
      S_FIRST:  next_state = S_SECOND;
      S_SECOND: next_state = S_THIRD;
      // wait until ready, extended write or verify skips wait
      S_THIRD:  next_state = (ready || ext_write || ch_mode[cur] == 2'b00) ? S_FOURTH : S_WAIT;
      S_WAIT:   next_state = ready ? S_FOURTH : S_WAIT;
      // keep bus while request and grant stay
      S_FOURTH: next_state = (any_req && bus_hold_grant) ? S_REQ : S_IDLE;
      default:  next_state = S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state <= S_IDLE;
    else state <= next_state;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cur <= 2'd0;
    else if (state == S_REQ && any_req) cur <= fcds_pick(active_req);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) bus_hold_request <= 1'b0;
    else bus_hold_request <= any_req || (next_state != S_IDLE && next_state != S_REQ);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) channel_grant_n <= 4'hf;
    else if (next_state == S_SECOND || next_state == S_THIRD ||
             next_state == S_WAIT || next_state == S_FOURTH)
      channel_grant_n <= ~(4'h1 << cur);
    else channel_grant_n <= 4'hf;
  end
  // address on pins and data pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_lo     <= 8'h00;
      data_out    <= 8'h00;
      data_oe_n   <= 1'b1;
      addr_strobe <= 1'b0;
    end else begin
      addr_strobe <= (next_state == S_FIRST);
      data_oe_n   <= !(next_state == S_FIRST);
      if (next_state == S_FIRST) begin
        addr_lo  <= ch_addr[fcds_pick(active_req)][7:0];
        data_out <= ch_addr[fcds_pick(active_req)][15:8];
      end
    end
  end
  // strobes by mode, none in verify
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_read_strobe_n  <= 1'b1;
      io_read_strobe_n   <= 1'b1;
      mem_write_strobe_n <= 1'b1;
      io_write_strobe_n  <= 1'b1;
    end else begin
      mem_read_strobe_n  <= !(ch_mode[cur] == 2'b10 && next_state inside
                              {S_SECOND, S_THIRD, S_WAIT});
      io_read_strobe_n   <= !(ch_mode[cur] == 2'b01 && next_state inside
                              {S_SECOND, S_THIRD, S_WAIT});
      mem_write_strobe_n <= !(ch_mode[cur] == 2'b01 && (next_state inside {S_THIRD, S_WAIT} ||
                              (ext_write && next_state == S_SECOND)));
      io_write_strobe_n  <= !(ch_mode[cur] == 2'b10 && (next_state inside {S_THIRD, S_WAIT} ||
                              (ext_write && next_state == S_SECOND)));
    end
  end
  // ================================================================
  // channel registers, step per completed cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        ch_addr[i]  <= 16'h0000;
        ch_count[i] <= 14'h0000;
        ch_mode[i]  <= 2'b00;
      end
      ch_en     <= 4'h0;
      ext_write <= 1'b0;
    end else begin
      if (wr_acc && paddr[7:6] == 2'b00) begin
        case (paddr[3:2])
          2'd0: ch_addr[fcds_ch(paddr)] <= pwdata[15:0];
          2'd1: ch_count[fcds_ch(paddr)] <= (pwdata[13:0] > fcds_pkg::MAX_COUNT) ?
                                            fcds_pkg::MAX_COUNT : pwdata[13:0];
          2'd2: ch_mode[fcds_ch(paddr)] <= pwdata[1:0];
          default: ;
        endcase
      end
      if (wr_acc && paddr == fcds_pkg::ADDR_CTRL) begin
        ch_en     <= pwdata[3:0];
        ext_write <= pwdata[fcds_pkg::CTRL_EXTW];
      end
      if (state == S_FOURTH) begin
        ch_addr[cur] <= ch_addr[cur] + 16'h0001;
        if (ch_count[cur] == 14'h0000) ch_en[cur] <= 1'b0;
        else ch_count[cur] <= ch_count[cur] - 14'h0001;
      end
    end
  end
  // count done and block mark at third state through fourth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_done <= 1'b0;
      block_mark <= 1'b0;
      done_flags <= 4'h0;
      for (int i = 0; i < 4; i++) mark_cnt[i] <= 7'h00;
    end else begin
      count_done <= (next_state inside {S_THIRD, S_WAIT, S_FOURTH}) &&
                    ch_count[cur] == 14'h0000;
      block_mark <= (next_state inside {S_THIRD, S_WAIT, S_FOURTH}) &&
                    mark_cnt[cur] == fcds_pkg::MARK_MOD;
      if (state == S_FOURTH) mark_cnt[cur] <= mark_cnt[cur] + 7'h01;
      // set wins over software clear
      if (wr_acc && paddr == fcds_pkg::ADDR_STATUS) done_flags <= done_flags & ~pwdata[3:0];
      if (state == S_FOURTH && ch_count[cur] == 14'h0000) done_flags[cur] <= 1'b1;
    end
  end
  // ================================================================
  // checks
  a_hold_follows: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_IDLE && !any_req) |=> !bus_hold_request) else $error("hold not released");
  a_req_to_hold: assert property (@(posedge clk) disable iff (!arst_n)
    any_req |=> bus_hold_request) else $error("hold not raised");
  a_wait_grant: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_REQ && !bus_hold_grant) |=> state != S_FIRST) else $error("left early");
  a_order_run: assert property (@(posedge clk) disable iff (!arst_n)
    state == S_FIRST |=> state == S_SECOND ##1 state == S_THIRD) else $error("bad order");
  a_wait_ready: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_WAIT && !ready) |=> state == S_WAIT) else $error("wait left");
  a_verify_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_SECOND && ch_mode[cur] == 2'b00) |=> mem_read_strobe_n && io_read_strobe_n)
    else $error("strobe in verify");
  a_read_strobe: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_SECOND && ch_mode[cur] == 2'b10) |-> !mem_read_strobe_n)
    else $error("no memory read");
  a_write_strobe: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_SECOND && ch_mode[cur] == 2'b01) |-> !io_read_strobe_n)
    else $error("no io read");
  a_grant_low: assert property (@(posedge clk) disable iff (!arst_n)
    state == S_SECOND |-> channel_grant_n == ~(4'h1 << cur)) else $error("grant wrong");

  // ================================================================
  // step sequences
  sequence s_addr_phase;
    state == S_FIRST;
  endsequence

  sequence s_strobe_phase;
    state == S_SECOND ##1 state == S_THIRD;
  endsequence

  sequence s_cycle_end;
    state == S_FOURTH;
  endsequence

  sequence s_quiet_pins;
    channel_grant_n == 4'hf && !addr_strobe && mem_read_strobe_n && io_read_strobe_n &&
    mem_write_strobe_n && io_write_strobe_n;
  endsequence

  // ================================================================
  // further checks
  a_addr_phase_run: assert property (@(posedge clk) disable iff (!arst_n)
    s_addr_phase |=> s_strobe_phase)
    else $error("address phase not followed by strobes");

  a_addr_pins: assert property (@(posedge clk) disable iff (!arst_n)
    s_addr_phase |-> {data_out, addr_lo} == ch_addr[cur])
    else $error("address pins wrong");

  a_addr_strobe_out: assert property (@(posedge clk) disable iff (!arst_n)
    s_addr_phase |-> addr_strobe && !data_oe_n)
    else $error("upper address not offered");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    state == S_IDLE |-> s_quiet_pins)
    else $error("activity in idle");

  a_end_next: assert property (@(posedge clk) disable iff (!arst_n)
    s_cycle_end |=> state inside {S_REQ, S_IDLE})
    else $error("fourth state not one clock");

  a_wait_exit: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_WAIT && ready) |=> state == S_FOURTH)
    else $error("ready not honoured");

  a_grant_loss: assert property (@(posedge clk) disable iff (!arst_n)
    (s_cycle_end and !bus_hold_grant) |=> state == S_IDLE)
    else $error("cycle after grant loss");

  a_mem_write: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_THIRD && ch_mode[cur] == 2'b01) |-> !mem_write_strobe_n)
    else $error("no memory write");

  a_io_write: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_THIRD && ch_mode[cur] == 2'b10) |-> !io_write_strobe_n)
    else $error("no io write");

  a_verify_silent: assert property (@(posedge clk) disable iff (!arst_n)
    (state inside {S_SECOND, S_THIRD, S_WAIT} && ch_mode[cur] == 2'b00) |->
    mem_read_strobe_n && io_read_strobe_n && mem_write_strobe_n && io_write_strobe_n)
    else $error("strobe in verify cycle");

  a_grant_single: assert property (@(posedge clk) disable iff (!arst_n)
    channel_grant_n != 4'hf |-> $onehot(~channel_grant_n))
    else $error("more than one grant");

  a_rank_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (state == S_REQ && active_req[0]) |=> cur == 2'd0)
    else $error("channel zero not first");

  a_done_last: assert property (@(posedge clk) disable iff (!arst_n)
    (s_cycle_end and ch_count[cur] == 14'h0000) |-> count_done)
    else $error("count done missing");

  a_done_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    state inside {S_IDLE, S_REQ, S_FIRST} |-> !count_done && !block_mark)
    else $error("count flag outside cycle");

  a_keep_bus: assert property (@(posedge clk) disable iff (!arst_n)
    (s_cycle_end and any_req and bus_hold_grant) |=> state == S_REQ && bus_hold_request)
    else $error("bus given up early");
endmodule

// *** fcds_far_side.sv ***
// far-side model: host bus owner, requesting peripherals, ready source
`timescale 1ns/1ps
module fcds_far_side (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] want,
  input  wire logic [3:0] wait_n,
  input  wire logic       bus_hold_request,
  input  wire logic [3:0] channel_grant_n,
  input  wire logic       addr_strobe,
  input  wire logic       count_done,
  output logic      [3:0] channel_request,
  output logic            bus_hold_grant,
  output logic            ready
);
  logic [3:0] stop;
  logic [3:0] last;
  logic [4:0] pos;
  // ================================================================
  // host side
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_hold_grant <= 1'b0;
    end else begin
      bus_hold_grant <= bus_hold_request;
    end
  end
  // ================================================================
  // peripherals
  assign last = ~channel_grant_n & {4{count_done}};
  // request held until grant with count done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop            <= 4'h0;
      channel_request <= 4'h0;
    end else begin
      stop            <= (stop | last) & want;
      channel_request <= want & ~stop & ~last;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos <= 5'h1f;
    end else begin
      pos <= addr_strobe ? 5'h00 : ((pos == 5'h1f) ? pos : pos + 5'h01);
    end
  end
  assign ready = (pos >= (5'h01 + {1'b0, wait_n}));
endmodule

// *** testbench.sv ***
// self-checking bench of the transfer sequencer
`timescale 1ns/1ps
module testbench;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        hold, hgnt, ready, astb, oe_n, done, mark, pd, pm;
  logic [7:0]  paddr, alo, dout;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  req, gnt_n, want, wait_n, strb, prev, fell, seen, first_gnt;
  logic [15:0] first_a, last_a;
  logic [1:0]  md [3] = '{fcds_pkg::XF_WRITE, fcds_pkg::XF_READ, fcds_pkg::XF_VERIFY};
  logic [3:0]  sm [3] = '{4'h6, 4'h9, 4'h0};
  int          wv [3] = '{0, 2, 0};
  int          n_errors, cmp_count, cyc, pos, n_x, n_g, n_tc, n_mk, rd_pos, wr_pos;

  fcds_sequencer i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_request(req), .bus_hold_grant(hgnt), .ready(ready),
    .bus_hold_request(hold), .channel_grant_n(gnt_n), .addr_lo(alo), .data_out(dout),
    .data_oe_n(oe_n), .addr_strobe(astb), .mem_read_strobe_n(strb[3]),
    .mem_write_strobe_n(strb[2]), .io_read_strobe_n(strb[1]),
    .io_write_strobe_n(strb[0]), .count_done(done), .block_mark(mark));
  fcds_far_side i_far (.clk(clk), .arst_n(arst_n), .want(want), .wait_n(wait_n),
    .bus_hold_request(hold), .channel_grant_n(gnt_n), .addr_strobe(astb),
    .count_done(done), .channel_request(req), .bus_hold_grant(hgnt), .ready(ready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ================================================================
  // monitor and timeout
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
    pos = astb ? 0 : pos + 1;
    fell = prev & ~strb;
    if (astb === 1'b1 && oe_n === 1'b0) begin
      n_x++;
      last_a = {dout, alo};
      if (n_x == 1) first_a = last_a;
    end
    if (fell[3] | fell[1]) rd_pos = pos;
    if (fell[2] | fell[0]) wr_pos = pos;
    seen = seen | fell;
    if (gnt_n !== 4'hf) n_g++;
    if (gnt_n !== 4'hf && first_gnt === 4'hf) first_gnt = gnt_n;
    if (done === 1'b1 && pd !== 1'b1) n_tc++;
    if (mark === 1'b1 && pm !== 1'b1) n_mk++;
    prev = strb;
    pd = done;
    pm = mark;
  end
  // ================================================================
  // tasks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task prog(input int ch, input logic [1:0] m, input logic [15:0] a, input logic [13:0] n);
    apb(1'b1, 8'(ch * 16), {16'h0000, a});
    apb(1'b1, 8'(ch * 16) + fcds_pkg::ADDR_COUNT, {18'h00000, n - 14'h0001});
    apb(1'b1, 8'(ch * 16) + fcds_pkg::ADDR_MODE, {30'h00000000, m});
  endtask
  task go(input logic [3:0] mask, input int ntc);
    n_x = 0; n_g = 0; n_tc = 0; n_mk = 0; seen = 4'h0; first_gnt = 4'hf;
    apb(1'b1, fcds_pkg::ADDR_CTRL, {28'h0000000, mask});
    want <= mask;
    @(posedge clk);
    while (n_tc < ntc || hold !== 1'b0) @(posedge clk);
    want <= 4'h0;
  endtask
  task give_verdict;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ================================================================
  // main sequence
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; want = 4'h0; wait_n = 4'h0; prev = 4'hf; pd = 1'b0; pm = 1'b0;
    n_errors = 0; cmp_count = 0; cyc = 0; pos = 0; n_x = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, fcds_pkg::ADDR_CTRL, 32'h0);
    chk(rd, fcds_pkg::CTRL_RST);
    chk(hold, 1'b0);
    chk(n_x, 0);
    apb(1'b0, 8'h48, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wait_n <= 4'(wv[i]);
      prog(1, md[i], 16'h12fe, 14'd3);
      go(4'h2, 1);
      chk(n_x, 3);
      chk(first_a, 16'h12fe);
      chk(last_a, 16'h1300);
      chk(n_g, 3 * (3 + wv[i]));
      chk(seen, sm[i]);
      if (i < 2) begin
        chk(rd_pos, 1);
        chk(wr_pos, 2);
      end
      apb(1'b0, fcds_pkg::ADDR_STATUS, 32'h0);
      chk(rd[1], 1'b1);
      apb(1'b1, fcds_pkg::ADDR_STATUS, 32'h0000_0002);
    end
    wait_n <= 4'h0;
    prog(2, fcds_pkg::XF_VERIFY, 16'h0000, 14'd128);
    go(4'h4, 1);
    chk(n_mk, 1);
    chk(n_x, 128);
    prog(0, fcds_pkg::XF_READ, 16'h0100, 14'd1);
    prog(3, fcds_pkg::XF_READ, 16'h0300, 14'd1);
    go(4'h9, 2);
    chk(first_gnt, 4'he);
    chk(n_x, 2);
    give_verdict();
  end
endmodule
